// *** verilog/pwm_sync_pkg.sv ***
// Function
// - Phase load enabled: sync strobe loads phase
// - Phase load disabled: sync strobe is ignored
// - Pass-through source forwards each incoming strobe
// - Period source strobes on counter equal period
// - Compare B source strobes on counter match
// - Disabled source never drives a strobe
// - Phase load and source select are independent
// - Phase value inert while loading disabled
// - Reloaded slave stays locked to master
// - Up-count period spans period plus one
package pwm_sync_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam int ADR_W = 4;

  localparam logic [ADR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADR_W-1:0] ADDR_PERIOD   = 4'h1;
  localparam logic [ADR_W-1:0] ADDR_PHASE    = 4'h2;
  localparam logic [ADR_W-1:0] ADDR_CMP_B    = 4'h3;
  localparam logic [ADR_W-1:0] ADDR_COUNTER  = 4'h4;
  localparam logic [ADR_W-1:0] ADDR_PRESCALE = 4'h5;
  localparam logic [ADR_W-1:0] ADDR_STATUS   = 4'h6;

  localparam int CTRL_PLE_BIT  = 0;
  localparam int CTRL_SEL_LSB  = 1;
  localparam int CTRL_RUN_BIT  = 3;
  localparam int STAT_IN_BIT   = 0;
  localparam int STAT_OUT_BIT  = 1;

  localparam logic [CNT_W-1:0] PERIOD_RST   = 16'hFFFF;
  localparam logic [CNT_W-1:0] PHASE_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_B_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] COUNTER_RST  = 16'h0000;
  localparam logic [PRE_W-1:0] PRESCALE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ONE      = 8'h01;

  typedef enum logic [1:0] {
    SRC_PASS  = 2'h0,
    SRC_PRD   = 2'h1,
    SRC_CMP_B = 2'h2,
    SRC_OFF   = 2'h3
  } sync_src_t;

  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;

  typedef struct packed {
    logic [ADR_W-1:0] addr;
    logic [CNT_W-1:0] wdata;
    logic             we;
    logic             re;
  } bus_req_t;

  typedef struct packed {
    logic eq_prev;
  } match_state_t;

  typedef struct packed {
    run_state_t       st;
    logic             ple;
    sync_src_t        sel;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] cmp_b;
    logic [CNT_W-1:0] counter;
    logic [PRE_W-1:0] prescale;
    logic [PRE_W-1:0] pre_cnt;
    logic             seen_in;
    logic             seen_out;
    logic             sync_out;
    logic [CNT_W-1:0] rdata;
  } tb_state_t;

endpackage

// *** verilog/match_strobe.sv ***
`timescale 1ns/1ns
module match_strobe #(
  parameter int W = 16
) (
  input  logic         ref_clk,
  input  logic         rst_b,
  input  logic [W-1:0] count,
  input  logic [W-1:0] match_value,
  output logic         hit
);

  pwm_sync_pkg::match_state_t st_r;
  pwm_sync_pkg::match_state_t st_nxt;
  logic                       eq;

  assign eq = (count == match_value);

  assign hit = eq & ~st_r.eq_prev;

  always_comb begin
    st_nxt = st_r;
    st_nxt.eq_prev = eq;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.eq_prev <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  property p_hit_single;
    @(posedge ref_clk) disable iff (!rst_b)
    hit |=> !hit;
  endproperty
  a_hit_single: assert property (p_hit_single)
    else $error("match strobe longer than one cycle");

endmodule

// *** verilog/pwm_time_base_sync_chain.sv ***
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
module pwm_time_base_sync_chain (
  input  logic                            ref_clk,
  input  logic                            rst_b,
  input  pwm_sync_pkg::bus_req_t          bus_req,
  output logic [pwm_sync_pkg::CNT_W-1:0]  rdata,
  input  logic                            sync_input_strobe,
  output logic                            sync_output_strobe,
  output logic [pwm_sync_pkg::CNT_W-1:0]  time_base_counter,
  output logic                            time_base_tick
);

  pwm_sync_pkg::tb_state_t s_r;
  pwm_sync_pkg::tb_state_t s_nxt;
  logic                    running;
  logic                    tick;
  logic                    load;
  logic                    prd_hit;
  logic                    cmp_b_hit;
  logic                    wr_status;

  assign running = (s_r.st == pwm_sync_pkg::ST_RUN);
  assign tick    = running & (s_r.pre_cnt == s_r.prescale);

  assign load = sync_input_strobe & s_r.ple;

  assign wr_status = bus_req.we & (bus_req.addr == pwm_sync_pkg::ADDR_STATUS);

  assign rdata              = s_r.rdata;
  assign sync_output_strobe = s_r.sync_out;
  assign time_base_counter  = s_r.counter;
  assign time_base_tick     = tick;

  match_strobe #(
    .W (pwm_sync_pkg::CNT_W)
  ) u_prd_match (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .count       (s_r.counter),
    .match_value (s_r.period),
    .hit         (prd_hit)
  );

  match_strobe #(
    .W (pwm_sync_pkg::CNT_W)
  ) u_cmp_b_match (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .count       (s_r.counter),
    .match_value (s_r.cmp_b),
    .hit         (cmp_b_hit)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;

    // Register writes
    if (bus_req.we) begin
      case (bus_req.addr)
        pwm_sync_pkg::ADDR_CTRL: begin
          s_nxt.ple = bus_req.wdata[pwm_sync_pkg::CTRL_PLE_BIT];
          s_nxt.sel = pwm_sync_pkg::sync_src_t'(
            bus_req.wdata[pwm_sync_pkg::CTRL_SEL_LSB +: 2]);
          s_nxt.st  = bus_req.wdata[pwm_sync_pkg::CTRL_RUN_BIT] ?
                      pwm_sync_pkg::ST_RUN : pwm_sync_pkg::ST_STOP;
        end
        pwm_sync_pkg::ADDR_PERIOD: begin
          s_nxt.period = bus_req.wdata;
        end
        pwm_sync_pkg::ADDR_PHASE: begin
          s_nxt.phase = bus_req.wdata;
        end
        pwm_sync_pkg::ADDR_CMP_B: begin
          s_nxt.cmp_b = bus_req.wdata;
        end
        pwm_sync_pkg::ADDR_PRESCALE: begin
          s_nxt.prescale = bus_req.wdata[pwm_sync_pkg::PRE_W-1:0];
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // Time-base stepping
    case (s_r.st)
      pwm_sync_pkg::ST_RUN: begin
        if (tick) begin
          s_nxt.pre_cnt = '0;
          if (s_r.counter == s_r.period) begin
            s_nxt.counter = '0;
          end else begin
            s_nxt.counter = s_r.counter + pwm_sync_pkg::CNT_ONE;
          end
        end else begin
          s_nxt.pre_cnt = s_r.pre_cnt + pwm_sync_pkg::PRE_ONE;
        end
      end
      pwm_sync_pkg::ST_STOP: begin
        s_nxt.pre_cnt = '0;
      end
      default: begin
        s_nxt.st      = pwm_sync_pkg::ST_STOP;
        s_nxt.pre_cnt = '0;
      end
    endcase

    if (load) begin
      s_nxt.counter = s_r.phase;
      s_nxt.pre_cnt = '0;
    end

    case (s_r.sel)
      pwm_sync_pkg::SRC_PASS:  s_nxt.sync_out = sync_input_strobe;
      pwm_sync_pkg::SRC_PRD:   s_nxt.sync_out = prd_hit;
      pwm_sync_pkg::SRC_CMP_B: s_nxt.sync_out = cmp_b_hit;
      default:                 s_nxt.sync_out = 1'b0;
    endcase

    // Sticky status, set beats clear
    if (wr_status) begin
      if (bus_req.wdata[pwm_sync_pkg::STAT_IN_BIT]) begin
        s_nxt.seen_in = 1'b0;
      end
      if (bus_req.wdata[pwm_sync_pkg::STAT_OUT_BIT]) begin
        s_nxt.seen_out = 1'b0;
      end
    end
    if (sync_input_strobe) begin
      s_nxt.seen_in = 1'b1;
    end
    if (s_r.sync_out) begin
      s_nxt.seen_out = 1'b1;
    end

    // Register reads
    if (bus_req.re) begin
      case (bus_req.addr)
        pwm_sync_pkg::ADDR_CTRL: begin
          s_nxt.rdata[pwm_sync_pkg::CTRL_PLE_BIT]      = s_r.ple;
          s_nxt.rdata[pwm_sync_pkg::CTRL_SEL_LSB +: 2] = s_r.sel;
          s_nxt.rdata[pwm_sync_pkg::CTRL_RUN_BIT]      = running;
        end
        pwm_sync_pkg::ADDR_PERIOD: begin
          s_nxt.rdata = s_r.period;
        end
        pwm_sync_pkg::ADDR_PHASE: begin
          s_nxt.rdata = s_r.phase;
        end
        pwm_sync_pkg::ADDR_CMP_B: begin
          s_nxt.rdata = s_r.cmp_b;
        end
        pwm_sync_pkg::ADDR_COUNTER: begin
          s_nxt.rdata = s_r.counter;
        end
        pwm_sync_pkg::ADDR_PRESCALE: begin
          s_nxt.rdata[pwm_sync_pkg::PRE_W-1:0] = s_r.prescale;
        end
        pwm_sync_pkg::ADDR_STATUS: begin
          s_nxt.rdata[pwm_sync_pkg::STAT_IN_BIT]  = s_r.seen_in;
          s_nxt.rdata[pwm_sync_pkg::STAT_OUT_BIT] = s_r.seen_out;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.st       <= pwm_sync_pkg::ST_STOP;
      s_r.ple      <= 1'b0;
      s_r.sel      <= pwm_sync_pkg::SRC_OFF;
      s_r.period   <= pwm_sync_pkg::PERIOD_RST;
      s_r.phase    <= pwm_sync_pkg::PHASE_RST;
      s_r.cmp_b    <= pwm_sync_pkg::CMP_B_RST;
      s_r.counter  <= pwm_sync_pkg::COUNTER_RST;
      s_r.prescale <= pwm_sync_pkg::PRESCALE_RST;
      s_r.pre_cnt  <= '0;
      s_r.seen_in  <= 1'b0;
      s_r.seen_out <= 1'b0;
      s_r.sync_out <= 1'b0;
      s_r.rdata    <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Checks

  sequence s_load;
    sync_input_strobe && s_r.ple;
  endsequence

  sequence s_top_tick;
    tick && (s_r.counter == s_r.period) && !load;
  endsequence

  sequence s_mid_tick;
    tick && (s_r.counter != s_r.period) && !load;
  endsequence

  property p_phase_load;
    @(posedge ref_clk) disable iff (!rst_b)
    s_load |=> (s_r.counter == $past(s_r.phase));
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("counter not loaded with phase on sync");

  property p_sync_ignored;
    @(posedge ref_clk) disable iff (!rst_b)
    (sync_input_strobe && !s_r.ple && !tick) |=> $stable(s_r.counter);
  endproperty
  a_sync_ignored: assert property (p_sync_ignored)
    else $error("counter disturbed by ignored sync");

  property p_pass_through;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_PASS) |=>
      (sync_output_strobe == $past(sync_input_strobe));
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("pass-through strobe mismatch");

  property p_prd_source;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_PRD) |=>
      (sync_output_strobe == $past(prd_hit));
  endproperty
  a_prd_source: assert property (p_prd_source)
    else $error("period match strobe mismatch");

  property p_prd_cause;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_PRD) ##1 sync_output_strobe |->
      ($past(s_r.counter) == $past(s_r.period));
  endproperty
  a_prd_cause: assert property (p_prd_cause)
    else $error("period strobe without match");

  property p_cmp_b_source;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_CMP_B) |=>
      (sync_output_strobe == $past(cmp_b_hit));
  endproperty
  a_cmp_b_source: assert property (p_cmp_b_source)
    else $error("compare B strobe mismatch");

  property p_cmp_b_cause;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_CMP_B) ##1 sync_output_strobe |->
      ($past(s_r.counter) == $past(s_r.cmp_b));
  endproperty
  a_cmp_b_cause: assert property (p_cmp_b_cause)
    else $error("compare B strobe without match");

  property p_src_off;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.sel == pwm_sync_pkg::SRC_OFF) |=> !sync_output_strobe;
  endproperty
  a_src_off: assert property (p_src_off)
    else $error("strobe driven while source disabled");

  property p_independent;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_load and (s_r.sel == pwm_sync_pkg::SRC_PASS)) |=>
      (sync_output_strobe && (s_r.counter == $past(s_r.phase)));
  endproperty
  a_independent: assert property (p_independent)
    else $error("load and pass-through interfere");

  property p_phase_inert;
    @(posedge ref_clk) disable iff (!rst_b)
    !s_r.ple |=> ($stable(s_r.counter) || (s_r.counter == '0) ||
      (s_r.counter == $past(s_r.counter) + pwm_sync_pkg::CNT_ONE));
  endproperty
  a_phase_inert: assert property (p_phase_inert)
    else $error("counter jumped with loading disabled");

  property p_locked;
    @(posedge ref_clk) disable iff (!rst_b)
    s_load |=> (s_r.pre_cnt == '0);
  endproperty
  a_locked: assert property (p_locked)
    else $error("tick phase not aligned after reload");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_b)
    s_top_tick |=> (s_r.counter == '0);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap at period");

  property p_step;
    @(posedge ref_clk) disable iff (!rst_b)
    s_mid_tick |=> (s_r.counter == $past(s_r.counter) + pwm_sync_pkg::CNT_ONE);
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");

  property p_out_single;
    @(posedge ref_clk) disable iff (!rst_b)
    (sync_output_strobe && (s_r.sel != pwm_sync_pkg::SRC_PASS)) |=>
      !sync_output_strobe;
  endproperty
  a_out_single: assert property (p_out_single)
    else $error("outgoing strobe longer than one cycle");

  property p_stop_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    (!running && !load) |=> $stable(s_r.counter);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved while stopped");

  property p_tick_gap;
    @(posedge ref_clk) disable iff (!rst_b)
    (tick && (s_r.prescale != '0) && !bus_req.we) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick repeated with prescale above zero");

  property p_seen_in;
    @(posedge ref_clk) disable iff (!rst_b)
    sync_input_strobe |=> s_r.seen_in;
  endproperty
  a_seen_in: assert property (p_seen_in)
    else $error("incoming strobe not recorded");

  property p_seen_out;
    @(posedge ref_clk) disable iff (!rst_b)
    sync_output_strobe |=> s_r.seen_out;
  endproperty
  a_seen_out: assert property (p_seen_out)
    else $error("outgoing strobe not recorded");

endmodule

// *** verif/sync_master_model.sv ***
`timescale 1ns/1ns
module sync_master_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        en,
  input  wire logic [15:0] period,
  output logic             strobe
);
  logic [15:0] count_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 16'h0000;
      strobe  <= 1'b0;
    end else if (en) begin
      count_r <= (count_r == period) ? 16'h0000 : count_r + 16'h0001;
      strobe  <= (count_r == period);
    end else begin
      strobe <= 1'b0;
    end
  end
endmodule

// *** verif/pwm_time_base_sync_chain_test.sv ***
`timescale 1ns/1ns
module pwm_time_base_sync_chain_test;
  logic                   ref_clk;
  logic                   rst_b;
  pwm_sync_pkg::bus_req_t req;
  logic [15:0]            rdata;
  logic                   sync_in;
  logic                   sync_tb;
  logic                   sync_output_strobe;
  logic [15:0]            time_base_counter;
  logic                   time_base_tick;
  logic                   model_strobe;
  logic                   model_en;
  logic [15:0]            model_per;
  logic                   use_model;
  logic [31:0]            seed = 32'h0000EECF;
  int                     mismatches = 0;
  int                     checks = 0;
  logic                   ple;
  logic [1:0]             sel;
  logic [15:0]            per;
  logic [15:0]            ph;
  logic [15:0]            cb;

  assign sync_in = use_model ? model_strobe : sync_tb;

  pwm_time_base_sync_chain dut (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .bus_req            (req),
    .rdata              (rdata),
    .sync_input_strobe  (sync_in),
    .sync_output_strobe (sync_output_strobe),
    .time_base_counter  (time_base_counter),
    .time_base_tick     (time_base_tick)
  );

  sync_master_model master (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .en      (model_en),
    .period  (model_per),
    .strobe  (model_strobe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.we    <= 1'b1;
    @(posedge ref_clk);
    req.we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    req.addr <= a;
    req.re   <= 1'b1;
    @(posedge ref_clk);
    req.re <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic reset(input int n);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(time_base_counter, 16'h0000);
    chk({15'h0000, sync_output_strobe}, 16'h0000);
    chk({15'h0000, time_base_tick}, 16'h0000);
  endtask

  task automatic cfg(input logic [7:0] pre);
    wr(pwm_sync_pkg::ADDR_PERIOD, per);
    wr(pwm_sync_pkg::ADDR_PHASE, ph);
    wr(pwm_sync_pkg::ADDR_CMP_B, cb);
    wr(pwm_sync_pkg::ADDR_PRESCALE, {8'h00, pre});
    wr(pwm_sync_pkg::ADDR_CTRL, {12'h000, 1'b1, sel, ple});
  endtask

  // Cycle by cycle model of counter and outgoing strobe, prescale zero
  task automatic watch(input int n);
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] e;
    logic [31:0] r;
    logic        s;
    logic        eo;
    c1 = 16'h0000;
    c2 = 16'h0000;
    for (int i = 0; i < n; i++) begin
      s = sync_in;
      r = rnd();
      @(posedge ref_clk);
      sync_tb <= !use_model && (r[2:0] == 3'h0);
      #1;
      e = (ple && s) ? ph : ((c1 == per) ? 16'h0000 : c1 + 16'h0001);
      case (sel)
        pwm_sync_pkg::SRC_PASS:  eo = s;
        pwm_sync_pkg::SRC_PRD:   eo = (c1 == per) && (c2 != per);
        pwm_sync_pkg::SRC_CMP_B: eo = (c1 == cb) && (c2 != cb);
        default:                 eo = 1'b0;
      endcase
      chk(time_base_counter, e);
      chk({15'h0000, sync_output_strobe}, {15'h0000, eo});
      c2 = c1;
      c1 = e;
    end
    sync_tb <= 1'b0;
  endtask

  task automatic measure(input logic [7:0] pre);
    logic [15:0] prev;
    int          t0;
    int          got;
    int          nt;
    int          ticks;
    prev = 16'h0000;
    t0 = -1;
    got = 0;
    nt = 0;
    ticks = 0;
    for (int i = 0; i < 12000 && got == 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (time_base_counter === 16'h0000 && prev === per) begin
        if (t0 >= 0) begin
          got = i - t0;
          ticks = nt;
        end
        t0 = i;
        nt = 0;
      end
      if (time_base_tick === 1'b1) begin
        nt++;
      end
      prev = time_base_counter;
    end
    if (got == 0) begin
      mismatches++;
    end
    chk(16'(got), 16'((per + 1) * (pre + 1)));
    chk(16'(ticks), per + 16'h0001);
  endtask

  initial begin
    logic [3:0]  addrs [9];
    logic [15:0] vals  [9];
    logic [31:0] r;
    logic [7:0]  pre;
    int          mult;
    addrs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
    vals  = '{16'h0006, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
              16'h0000, 16'h0000, 16'h0000};
    rst_b = 1'b0;
    req = '0;
    sync_tb = 1'b0;
    use_model = 1'b0;
    model_en = 1'b0;
    model_per = 16'h0000;
    reset(20);
    for (int i = 0; i < 9; i++) begin
      rd(addrs[i], vals[i]);
    end
    wr(pwm_sync_pkg::ADDR_COUNTER, 16'h1234);
    rd(pwm_sync_pkg::ADDR_COUNTER, 16'h0000);
    @(posedge ref_clk);
    sync_tb <= 1'b1;
    @(posedge ref_clk);
    sync_tb <= 1'b0;
    rd(pwm_sync_pkg::ADDR_STATUS, 16'h0001);
    @(posedge ref_clk);
    req.addr  <= pwm_sync_pkg::ADDR_STATUS;
    req.wdata <= 16'h0003;
    req.we    <= 1'b1;
    sync_tb   <= 1'b1;
    @(posedge ref_clk);
    req.we  <= 1'b0;
    sync_tb <= 1'b0;
    rd(pwm_sync_pkg::ADDR_STATUS, 16'h0001);
    wr(pwm_sync_pkg::ADDR_STATUS, 16'h0003);
    rd(pwm_sync_pkg::ADDR_STATUS, 16'h0000);
    $display("Test reset values done");
    for (int k = 0; k < 8; k++) begin
      reset(2);
      r = rnd();
      ple = k[0];
      sel = k[2:1];
      per = 16'(4 + r[3:0]);
      ph = 16'(r[15:8] % (per + 1));
      cb = 16'(r[31:24] % (per + 1));
      cfg(8'h00);
      watch(150);
      $display("Test sync mode %0d done", k);
    end
    reset(2);
    r = rnd();
    use_model = 1'b1;
    mult = 1 + r[1:0] % 3;
    ple = 1'b1;
    sel = pwm_sync_pkg::SRC_PASS;
    per = 16'(3 + r[7:4] % 6);
    ph = 16'(r[15:8] % (per + 1));
    cb = 16'h0000;
    model_per = 16'(mult * (per + 1) - 1);
    cfg(8'h00);
    model_en <= 1'b1;
    watch(200);
    use_model = 1'b0;
    model_en <= 1'b0;
    $display("Test master slave lock done");
    reset(2);
    r = rnd();
    ple = 1'b0;
    sel = pwm_sync_pkg::SRC_OFF;
    per = 16'd1200;
    pre = {6'h00, r[1:0]};
    cfg(pre);
    measure(pre);
    $display("Test period length done");
    wrap_up();
  end
endmodule
